// *** hdl/flash_host_pkg.sv ***
// Package with command codes, addresses and timing for the flash host controller.
package flash_host_pkg;
  // Flash bus widths.
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  // Unlock cycles and command codes, kept configurable as constants.
  localparam logic [16:0] UNLOCK1_ADDR = 17'h0_0555;
  localparam logic [16:0] UNLOCK2_ADDR = 17'h0_02AA;
  localparam logic [15:0] UNLOCK1_DATA = 16'h0_00AA;
  localparam logic [15:0] UNLOCK2_DATA = 16'h0_0055;
  localparam logic [15:0] CMD_RESET = 16'h0_00F0;
  localparam logic [15:0] CMD_IDENT = 16'h0_0090;
  localparam logic [15:0] CMD_PROGRAM = 16'h0_00A0;
  // Identification offsets in word mode.
  localparam logic [16:0] ID_MAKER_OFS = 17'h0_0000;
  localparam logic [16:0] ID_PART_OFS = 17'h0_0001;
  localparam logic [16:0] ID_PROT_OFS = 17'h0_0002;
  // Strobe timing in ns and derived cycle counts at 200 MHz.
  localparam int CLK_NS = 5;
  localparam int STROBE_NS = 50;
  localparam int HOLD_NS = 20;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  // Software register offsets.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  // Operation codes written to the control register.
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_PROGRAM = 3'h2;
  localparam logic [2:0] OP_IDENT = 3'h3;
  localparam logic [2:0] OP_RESET = 3'h4;
  localparam logic [2:0] OP_WRITE = 3'h5;
  // Bit positions in the status register.
  localparam int ST_BUSY = 0;
  localparam int ST_FLASH_READY = 1;
  localparam int ST_TIME_LIMIT = 2;
  localparam int ST_IN_IDENT = 3;
  localparam int ST_DONE = 4;
endpackage

// *** hdl/flash_host_ctrl.sv ***
// Host controller that issues read, program, identify and reset sequences to a parallel NOR flash.
`timescale 1ns/10ps
module flash_host_ctrl
  import flash_host_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // Software register port.
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Flash pins.
  output logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_reset_n,
  output logic flash_word_n,
  input wire logic ready_busy_n
);

  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_WSETUP = 7'b000_0010,
    ST_WPULSE = 7'b000_0100,
    ST_WHOLD = 7'b000_1000,
    ST_RPULSE = 7'b001_0000,
    ST_RHOLD = 7'b010_0000,
    ST_WAITRDY = 7'b100_0000
  } state_e;

  state_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [1:0] step, next_step;
  logic [2:0] op, next_op;
  logic [ADDR_W-1:0] addr, next_addr, tgt_addr, next_tgt_addr;
  logic [DATA_W-1:0] wdat, next_wdat, tgt_data, next_tgt_data, rdat, next_rdat;
  logic busy, next_busy, done, next_done, in_ident, next_in_ident;
  logic ce_n, next_ce_n, we_n, next_we_n, oe_n, next_oe_n, dq_oe, next_dq_oe;
  logic byte_mode, next_byte_mode, hold_reset, next_hold_reset;
  logic [31:0] next_reg_rdata;
  logic [2:0] rb_sync;
  logic rb_level, next_rb_level;

  // Sequence table for one step of each multi-cycle command.
  function automatic logic [ADDR_W+DATA_W-1:0] seq_cycle(input logic [1:0] s, input logic [15:0] cmd);
    case (s)
      2'd0: seq_cycle = {UNLOCK1_ADDR, UNLOCK1_DATA};
      2'd1: seq_cycle = {UNLOCK2_ADDR, UNLOCK2_DATA};
      default: seq_cycle = {UNLOCK1_ADDR, cmd};
    endcase
  endfunction

  // Input synchroniser; the first stage feeds only the second.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      // Reset to the idle level of the pin so no false busy follows reset.
      rb_sync <= 3'h7;
    else if (clk_en)
      rb_sync <= {rb_sync[1:0], ready_busy_n};
  end

  always_comb
  begin
    next_rb_level = rb_level;
    if (rb_sync[1] == rb_sync[2])
      next_rb_level = rb_sync[2];
  end

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_step = step;
    next_op = op;
    next_addr = addr;
    next_wdat = wdat;
    next_tgt_addr = tgt_addr;
    next_tgt_data = tgt_data;
    next_rdat = rdat;
    next_busy = busy;
    next_done = done;
    next_in_ident = in_ident;
    next_ce_n = ce_n;
    next_we_n = we_n;
    next_oe_n = oe_n;
    next_dq_oe = dq_oe;
    next_byte_mode = byte_mode;
    next_hold_reset = hold_reset;
    next_reg_rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL: next_reg_rdata = {29'h0, op};
        REG_ADDR: next_reg_rdata = {15'h0, tgt_addr};
        REG_DATA: next_reg_rdata = {16'h0, tgt_data};
        REG_STATUS:
        begin
          next_reg_rdata[ST_BUSY] = busy;
          next_reg_rdata[ST_FLASH_READY] = rb_level;
          next_reg_rdata[ST_TIME_LIMIT] = rdat[5];
          next_reg_rdata[ST_IN_IDENT] = in_ident;
          next_reg_rdata[ST_DONE] = done;
        end
        REG_RDATA: next_reg_rdata = {16'h0, rdat};
        default: next_reg_rdata = 32'h0000_0000;
      endcase
    end
    if (reg_wr && reg_addr == REG_ADDR)
      next_tgt_addr = reg_wdata[ADDR_W-1:0];
    if (reg_wr && reg_addr == REG_DATA)
      next_tgt_data = reg_wdata[DATA_W-1:0];
    // Status read clears done, but a new completion in the same cycle wins.
    if (reg_rd && reg_addr == REG_STATUS)
      next_done = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (reg_wr && reg_addr == REG_CTRL && !busy)
        begin
          next_op = reg_wdata[2:0];
          next_byte_mode = reg_wdata[4];
          next_hold_reset = reg_wdata[8];
          next_busy = 1'b1;
          next_step = 2'd0;
          next_cnt = CNT_W'(STROBE_CYC);
          if (reg_wdata[2:0] == OP_READ)
          begin
            next_addr = tgt_addr;
            next_ce_n = 1'b0;
            next_oe_n = 1'b0;
            next_state = ST_RPULSE;
          end
          else
            next_state = ST_WSETUP;
        end
      end
      ST_WSETUP:
      begin
        // Address and data settle one cycle before the strobes fall, so the later falling edge sees them.
        if (!dq_oe)
        begin
          if (op == OP_PROGRAM && step == 2'd3)
            {next_addr, next_wdat} = {tgt_addr, tgt_data};
          else if (op == OP_PROGRAM)
            {next_addr, next_wdat} = seq_cycle(step, CMD_PROGRAM);
          else if (op == OP_IDENT)
            {next_addr, next_wdat} = seq_cycle(step, CMD_IDENT);
          else if (op == OP_WRITE)
            {next_addr, next_wdat} = {tgt_addr, tgt_data};
          else
            {next_addr, next_wdat} = {tgt_addr, CMD_RESET};
          next_oe_n = 1'b1;
          next_dq_oe = 1'b1;
        end
        else
        begin
          next_ce_n = 1'b0;
          next_we_n = 1'b0;
          next_state = ST_WPULSE;
        end
      end
      ST_WPULSE:
      begin
        next_cnt = cnt - CNT_W'(1);
        if (cnt == CNT_W'(1))
        begin
          next_we_n = 1'b1;
          next_cnt = CNT_W'(HOLD_CYC);
          next_state = ST_WHOLD;
        end
      end
      ST_WHOLD:
      begin
        // Chip select rises a cycle after the write strobe, so the write strobe edge latches the data.
        next_ce_n = 1'b1;
        next_cnt = cnt - CNT_W'(1);
        if (cnt == CNT_W'(1))
        begin
          next_dq_oe = 1'b0;
          next_cnt = CNT_W'(STROBE_CYC);
          if ((op == OP_PROGRAM && step != 2'd3) || (op == OP_IDENT && step != 2'd2))
          begin
            next_step = step + 2'd1;
            next_state = ST_WSETUP;
          end
          else if (op == OP_PROGRAM)
            next_state = ST_WAITRDY;
          else
          begin
            next_in_ident = (op == OP_IDENT);
            next_hold_reset = 1'b0;
            next_busy = 1'b0;
            next_done = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
      ST_RPULSE:
      begin
        next_cnt = cnt - CNT_W'(1);
        if (cnt == CNT_W'(1))
        begin
          next_rdat = flash_dq_in;
          next_ce_n = 1'b1;
          next_oe_n = 1'b1;
          next_cnt = CNT_W'(HOLD_CYC);
          next_state = ST_RHOLD;
        end
      end
      ST_RHOLD:
      begin
        next_cnt = cnt - CNT_W'(1);
        if (cnt == CNT_W'(1))
        begin
          next_busy = 1'b0;
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_WAITRDY:
      begin
        if (cnt != '0)
          next_cnt = cnt - CNT_W'(1);
        else if (rb_level)
        begin
          next_busy = 1'b0;
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      cnt <= '0;
      step <= 2'd0;
      op <= 3'h0;
      addr <= '0;
      wdat <= '0;
      tgt_addr <= '0;
      tgt_data <= '0;
      rdat <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      in_ident <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      dq_oe <= 1'b0;
      byte_mode <= 1'b0;
      hold_reset <= 1'b0;
      reg_rdata <= 32'h0000_0000;
      rb_level <= 1'b1;
    end
    else if (clk_en)
    begin
      state <= next_state;
      cnt <= next_cnt;
      step <= next_step;
      op <= next_op;
      addr <= next_addr;
      wdat <= next_wdat;
      tgt_addr <= next_tgt_addr;
      tgt_data <= next_tgt_data;
      rdat <= next_rdat;
      busy <= next_busy;
      done <= next_done;
      in_ident <= next_in_ident;
      ce_n <= next_ce_n;
      we_n <= next_we_n;
      oe_n <= next_oe_n;
      dq_oe <= next_dq_oe;
      byte_mode <= next_byte_mode;
      hold_reset <= next_hold_reset;
      reg_rdata <= next_reg_rdata;
      rb_level <= next_rb_level;
    end
  end

  assign flash_addr = addr;
  assign flash_dq_out = wdat;
  assign flash_dq_oe = dq_oe;
  assign flash_ce_n = ce_n;
  assign flash_we_n = we_n;
  assign flash_oe_n = oe_n;
  // Reset pin is pulsed low during an OP_RESET with bit 8 set.
  assign flash_reset_n = ~hold_reset;
  assign flash_word_n = ~byte_mode;

endmodule // flash_host_ctrl

// *** dv/flash_host_chk.sv ***
// Checker of flash strobe timing and register port behaviour.
`timescale 1ns/10ps
module flash_host_chk
  import flash_host_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Register port.
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Flash pins.
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence we_low10;
    !flash_we_n[*8] ##1 !flash_we_n[*2];
  endsequence
  sequence oe_low10;
    !flash_oe_n[*8] ##1 !flash_oe_n[*2];
  endsequence
  write_gate_a: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe without chip select");
  read_gate_a: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n)
    else $error("output strobe with write strobe");
  bus_fight_a: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("data driven during read");
  we_width_a: assert property ($fell(flash_we_n) |-> we_low10 ##1 flash_we_n)
    else $error("write pulse not ten cycles");
  oe_width_a: assert property ($fell(flash_oe_n) |-> oe_low10 ##1 flash_oe_n)
    else $error("read pulse not ten cycles");
  latch_stable_a: assert property (!flash_we_n && !$fell(flash_we_n) |->
    $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved in write pulse");
  we_gap_a: assert property ($rose(flash_we_n) |-> flash_we_n[*5])
    else $error("write pulses too close");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
endmodule // flash_host_chk
bind flash_host_ctrl flash_host_chk flash_host_chk_i (.clock, .rst, .reg_rd, .reg_rdata, .flash_addr,
  .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_we_n, .flash_oe_n);

// *** dv/flash_dev_model.sv ***
// Behavioural model of the flash command logic.
`timescale 1ns/10ps
module flash_dev_model
  import flash_host_pkg::*;
#(
  // Arbitrary identification values.
  parameter logic [15:0] MAKER = 16'h0011,
  parameter logic [15:0] PART = 16'h0066,
  parameter int BUSY_NS = 400
)
(
  // Flash pins.
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_out,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_reset_n,
  output logic [DATA_W-1:0] dq,
  output logic ready_busy_n
);
  logic [15:0] mem [256];
  logic [16:0] la;
  logic [15:0] rval;
  logic [15:0] last = 16'h0;
  logic [1:0] st = 2'h0;
  logic ident = 1'b0;
  function automatic logic prot(input logic [16:0] a);
    return a[16:15] == 2'b11;
  endfunction
  initial
  begin
    ready_busy_n = 1'b1;
    foreach (mem[i]) mem[i] = 16'hFFFF;
  end
  always @(negedge flash_we_n) la = flash_addr;
  always @(posedge flash_we_n)
    if (!flash_ce_n && flash_oe_n && flash_reset_n && ready_busy_n)
    begin
      if (flash_dq_out == CMD_RESET)
      begin
        st = 0;
        ident = 0;
      end
      else if (st == 3)
      begin
        st = 0;
        ready_busy_n = 0;
        if (!prot(la)) mem[la[7:0]] &= flash_dq_out;
      end
      else if (st == 0 && la == UNLOCK1_ADDR && flash_dq_out == UNLOCK1_DATA) st = 1;
      else if (st == 1 && la == UNLOCK2_ADDR && flash_dq_out == UNLOCK2_DATA) st = 2;
      else if (st == 2 && la == UNLOCK1_ADDR && flash_dq_out == CMD_PROGRAM) st = 3;
      else
      begin
        ident = ident || (st == 2 && la == UNLOCK1_ADDR && flash_dq_out == CMD_IDENT);
        st = 0;
      end
    end
  always @(negedge ready_busy_n) ready_busy_n <= #(BUSY_NS) 1'b1;
  always @(negedge flash_reset_n)
  begin
    st = 0;
    ident = 0;
  end
  assign rval = !ident ? mem[flash_addr[7:0]] : flash_addr[1:0] == 2'd0 ? MAKER :
    flash_addr[1:0] == 2'd1 ? PART : {15'h0, prot(flash_addr)};
  // Released bus shows the inverse of the last value, so stale data never matches.
  assign dq = (!flash_ce_n && !flash_oe_n) ? rval : ~last;
  always @(posedge flash_oe_n) last = rval;
endmodule // flash_dev_model

// *** dv/flash_host_ctrl_tb.sv ***
// Self-checking testbench of the flash host controller.
`timescale 1ns/10ps
module flash_host_ctrl_tb
  import flash_host_pkg::*;
;
  localparam logic [15:0] MAKER = 16'h0011;
  localparam logic [15:0] PART = 16'h0066;
  logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, rd_q = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, e, m, exp_q[$], msk_q[$];
  logic [16:0] pa, flash_addr;
  logic [15:0] pd, v, flash_dq_in, flash_dq_out;
  logic flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n, flash_word_n, ready_busy_n;
  int fail_count = 0, tests_run = 0, seed = 4;
  flash_host_ctrl flash_host_ctrl_i (.clock, .rst, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .flash_addr, .flash_dq_in, .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_we_n,
    .flash_oe_n, .flash_reset_n, .flash_word_n, .ready_busy_n);
  flash_dev_model #(.MAKER(MAKER), .PART(PART)) flash_dev_model_i (.flash_addr, .flash_dq_out, .flash_ce_n,
    .flash_we_n, .flash_oe_n, .flash_reset_n, .dq(flash_dq_in), .ready_busy_n);
  initial forever #2.5 clock = ~clock;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  always @(posedge clock)
  begin
    if (rd_q)
    begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m != 0) check("reg_rdata", e, reg_rdata & m);
    end
    rd_q <= reg_rd;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] k);
    exp_q.push_back(x);
    msk_q.push_back(k);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask
  task automatic op(input logic [2:0] c, input logic [16:0] a, input logic [15:0] d, input logic [8:0] f);
    int n = 0;
    wr(REG_ADDR, {15'h0, a});
    wr(REG_DATA, {16'h0, d});
    wr(REG_CTRL, {23'h0, f} | {29'h0, c});
    do
    begin
      rd(REG_STATUS, 32'h0, 32'h0);
      #1;
      n++;
    end
    while (reg_rdata[ST_BUSY] !== 1'b0 && n < 200);
    check("busy", 32'h0, {31'h0, reg_rdata[ST_BUSY]});
  endtask
  task automatic rdback(input logic [16:0] a, input logic [15:0] x);
    op(OP_READ, a, 16'h0, 9'h0);
    rd(REG_RDATA, {16'h0, x}, 32'h0000_FFFF);
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #200_000;
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    rd(REG_STATUS, 32'h2, 32'h1F);
    rd(4'hF, 32'h0, 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++)
    begin
      pa = {2'b00, 7'($random(seed)), 8'(i)};
      pd = 16'($random(seed));
      v = 16'($random(seed));
      op(OP_PROGRAM, pa, pd, {4'h0, i[0], 4'h0});
      rdback(pa, pd);
      op(OP_PROGRAM, pa, v, 9'h0);
      rdback(pa, pd & v);
    end
    $display("program test done");
    op(OP_PROGRAM, 17'h1_8010, 16'h1234, 9'h0);
    rdback(17'h1_8010, 16'hFFFF);
    op(OP_IDENT, 17'h0, 16'h0, 9'h0);
    rd(REG_STATUS, 32'h8, 32'h8);
    rdback(17'h0, MAKER);
    rdback(17'h1, PART);
    rdback(17'h1_8002, 16'h1);
    rdback(17'h0_8002, 16'h0);
    op(OP_RESET, 17'h0_1234, 16'h0, 9'h0);
    rd(REG_STATUS, 32'h0, 32'h8);
    rdback(17'h1_8010, 16'hFFFF);
    $display("identify test done");
    for (int j = 0; j < 2; j++)
    begin
      op(OP_WRITE, UNLOCK1_ADDR, UNLOCK1_DATA, 9'h0);
      op(OP_WRITE, UNLOCK2_ADDR, UNLOCK2_DATA, 9'h0);
      op(OP_WRITE, UNLOCK1_ADDR, CMD_PROGRAM, 9'h0);
      op(OP_RESET, 17'h0, 16'h0, {j[0], 8'h0});
      op(OP_WRITE, 17'h0_0020, 16'h0, 9'h0);
      rdback(17'h0_0020, 16'hFFFF);
    end
    $display("abort test done");
    repeat (3) @(posedge clock);
    report_and_stop();
  end
endmodule // flash_host_ctrl_tb
